// >>> hw/ars_params.svh
/*
  Register offsets, field positions, reset values and scaling
  constants of the analog reference scaler.
  Assumes: included by bare name; percentages are in 0.01 % units.
*/
`ifndef ARS_PARAMS_SVH
`define ARS_PARAMS_SVH
// Register byte offsets
`define ARS_ADR_CTRL  8'h00
`define ARS_ADR_STAT  8'h04
`define ARS_ADR_FMIN  8'h08
`define ARS_ADR_FMAX  8'h0c
`define ARS_ADR_PMIN  8'h10
`define ARS_ADR_PMAX  8'h14
`define ARS_ADR_REF   8'h18
// Point block 0x40..0x7f: addr[5:4] set, addr[3:2] coordinate
`define ARS_PTS_TAG   2'h1
// Control fields and reset value
`define ARS_CTRL_PCT  3
`define ARS_CTRL_MON  4
`define ARS_CTRL_RST  8'h03
// Scale: 100.00 %, its double and its negative
`define ARS_FULL      16'h2710
`define ARS_FULL2     16'h4e20
`define ARS_Y_NEG     16'hd8f0
// Fixed characteristic points (2 %, 22 %, 98 % of full scale)
`define ARS_FIX_X1    16'h00c8
`define ARS_I420_X1   16'h0898
`define ARS_FIX_X2    16'h2648
// Low-signal threshold, 1 V of 10 V or 2 mA of 20 mA
`define ARS_LOW_LIM   16'h03e8
// Limits and reset values of the limit registers
`define ARS_F_LIM     16'he9fc
`define ARS_P_LIM     16'h7530
`define ARS_FMIN_RST  16'h015e
`define ARS_FMAX_RST  16'h1388
`define ARS_PMIN_RST  16'h0000
`define ARS_PMAX_RST  16'h2710
// Point reset values
`define ARS_X1_RST    16'h00c8
`define ARS_Y1_RST    16'h0000
`define ARS_X2_RST    16'h2648
`define ARS_Y2_RST    16'h2710
`endif

// >>> hw/ars_pkg.sv
/*
  Types of the analog reference scaler.
  Assumes: compiled before every other file of the block.
*/
package ars_pkg;
  // Input mode selector codes
  typedef enum logic [2:0] {
    ARS_VOLT   = 3'h1,
    ARS_CUR    = 3'h2,
    ARS_CUR420 = 3'h5,
    ARS_VCHAR  = 3'h6,
    ARS_CCHAR  = 3'h7
  } ars_mode_t;
  // Computation sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_DIV1  = 3'h1,
    ST_SCALE = 3'h2,
    ST_DIV2  = 3'h3
  } ars_fsm_t;
endpackage : ars_pkg

// >>> hw/ars_div_if.sv
/*
  Link between the scaler sequencer and its divider.
  Assumes: one clock shared by both ends.
*/
`timescale 1ns/100ps
`default_nettype none
interface ars_div_if;
  logic        start;
  logic [31:0] num;
  logic [31:0] den;
  logic        done;
  logic [31:0] quo;
  modport ctl (output start, num, den, input done, quo);
  modport unit (input start, num, den, output done, quo);
endinterface : ars_div_if
`default_nettype wire

// >>> hw/ars_divider.sv
/*
  Restoring unsigned divider, one quotient bit per clock.
  Assumes: start is a one-cycle pulse while idle; den is nonzero.
*/
`timescale 1ns/100ps
`default_nettype none
module ars_divider (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Sequencer side
  ars_div_if.unit   div
);
  typedef struct packed {
    logic        busy;
    logic [5:0]  cnt;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] den;
    logic        done;
  } ars_div_t;

  ars_div_t    s_q;
  ars_div_t    s_d;
  logic [32:0] trial;

  // Shift in the next dividend bit
  assign trial = {s_q.rem, s_q.quo[31]};

  // Next state of the divider
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy && div.start) begin
      s_d.busy = 1'b1;
      s_d.cnt  = 6'h20;
      s_d.rem  = 32'h0;
      s_d.quo  = div.num;
      s_d.den  = div.den;
    end else if (s_q.busy) begin
      s_d.quo = {s_q.quo[30:0], 1'b0};
      if (trial >= {1'b0, s_q.den}) begin
        s_d.rem    = 32'(trial - {1'b0, s_q.den});
        s_d.quo[0] = 1'b1;
      end else begin
        s_d.rem = trial[31:0];
      end
      s_d.cnt = s_q.cnt - 6'h01;
      if (s_q.cnt == 6'h01) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign div.done = s_q.done;
  assign div.quo  = s_q.quo;

  // Done shows 33 cycles after the start is taken: 32 busy, 1 flag
  div_time_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!s_q.busy && div.start) |-> ##33 s_q.done)
    else $error("divider result late");
endmodule : ars_divider
`default_nettype wire

// >>> hw/ars_scaler.sv
/*
  Analog reference scaler: maps a digitised analog sample through a
  fixed or two-point characteristic onto a bounded reference.
  Assumes: sample code 2**ADC_W equals 10 V or 20 mA full scale;
  register port strobes are one cycle long and never overlap.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ars_params.svh"
module ars_scaler #(
  parameter int ADC_W = 12
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Register port
  input  wire logic [7:0]       regAddr,
  input  wire logic [31:0]      regWrData,
  input  wire logic             regWrStb,
  input  wire logic             regRdStb,
  output logic      [31:0]      regRdData,
  // Converted analog sample
  input  wire logic [ADC_W-1:0] sampleIn,
  input  wire logic             sampleValid,
  // Drive state
  input  wire logic [1:0]       dataSet,
  input  wire logic             dirRev,
  input  wire logic [15:0]      slipComp,
  // Setpoint path
  output logic      [16:0]      refOut,
  output logic                  refValid,
  output logic                  reverseOut,
  output logic                  lowWarn
);
  localparam int LAT = 80;

  typedef struct packed {
    ars_pkg::ars_fsm_t      st;
    logic [7:0]             ctrl;
    logic [15:0]            fmin;
    logic [15:0]            fmax;
    logic [15:0]            pmin;
    logic [15:0]            pmax;
    logic [3:0][3:0][15:0]  pts;
    logic                   pend;
    logic [15:0]            pendX;
    logic                   fixed;
    logic                   neg;
    logic signed [15:0]     y1;
    logic signed [15:0]     yPct;
    logic [16:0]            maxEff;
    logic [15:0]            minEff;
    logic                   dStart;
    logic [31:0]            dNum;
    logic [31:0]            dDen;
    logic [16:0]            refVal;
    logic                   valid;
    logic                   rev;
    logic                   warn;
    logic                   rdOk;
    logic [31:0]            rd;
  } ars_regs_t;

  ars_regs_t              s_q;
  ars_regs_t              s_d;
  ars_div_if              div ();
  logic [ADC_W+15:0]      xProd;
  logic [15:0]            xIn;
  logic [2:0]             mode;
  logic                   isFixed;
  logic                   isAnalog;
  logic [3:0][15:0]       selPts;
  logic [15:0]            px1;
  logic [15:0]            px2;
  logic signed [15:0]     py1;
  logic signed [15:0]     py2;
  logic [15:0]            xLo;
  logic [15:0]            xHi;
  logic [15:0]            xc;
  logic signed [16:0]     dx;
  logic signed [16:0]     xr;
  logic signed [16:0]     dy;
  logic signed [33:0]     num;
  logic [16:0]            maxNow;
  logic [15:0]            qc;
  logic signed [16:0]     ys;
  logic [14:0]            mag;
  logic [16:0]            rq;
  logic [16:0]            rLim;

  // Saturate an unsigned write to an upper limit
  function automatic logic [15:0] satU(input logic [31:0] v,
                                       input logic [15:0] m);
    satU = (v > {16'h0, m}) ? m : v[15:0];
  endfunction : satU

  // Saturate a signed write to plus or minus full scale
  function automatic logic [15:0] satY(input logic [31:0] v);
    if ($signed(v) > $signed({16'h0, `ARS_FULL})) begin
      satY = `ARS_FULL;
    end else if ($signed(v) < $signed({16'hffff, `ARS_Y_NEG})) begin
      satY = `ARS_Y_NEG;
    end else begin
      satY = v[15:0];
    end
  endfunction : satY

  ars_divider u_div (
    .clk     (clk),
    .reset_n (reset_n),
    .div     (div.unit)
  );

  // Divider request from registered state
  assign div.start = s_q.dStart;
  assign div.num   = s_q.dNum;
  assign div.den   = s_q.dDen;

  // Sample code to 0.01 % of 10 V or 20 mA
  assign xProd = sampleIn * `ARS_FULL;
  assign xIn   = xProd[ADC_W+15:ADC_W];

  // Mode decode
  assign mode     = s_q.ctrl[2:0];
  assign isFixed  = (mode == ars_pkg::ARS_VOLT) ||
                    (mode == ars_pkg::ARS_CUR) ||
                    (mode == ars_pkg::ARS_CUR420);
  assign isAnalog = isFixed || (mode == ars_pkg::ARS_VCHAR) ||
                    (mode == ars_pkg::ARS_CCHAR);

  // Active point set or fixed curve points
  assign selPts = s_q.pts[dataSet];
  assign px1 = !isFixed ? selPts[0] :
               (mode == ars_pkg::ARS_CUR420) ? `ARS_I420_X1 :
               `ARS_FIX_X1;
  assign px2 = isFixed ? `ARS_FIX_X2 : selPts[2];
  assign py1 = isFixed ? 16'sh0000 : $signed(selPts[1]);
  assign py2 = isFixed ? $signed(`ARS_FULL) : $signed(selPts[3]);

  // Hold the input inside the point span for dead ends
  assign xLo = (px1 < px2) ? px1 : px2;
  assign xHi = (px1 < px2) ? px2 : px1;
  assign xc  = (s_q.pendX < xLo) ? xLo :
               (s_q.pendX > xHi) ? xHi : s_q.pendX;

  // Line equation numerator and slope denominator
  assign dx  = $signed({1'b0, px2}) - $signed({1'b0, px1});
  assign xr  = $signed({1'b0, xc}) - $signed({1'b0, px1});
  assign dy  = 17'(py2) - 17'(py1);
  assign num = dy * xr;

  // Maximum with slip in frequency mode
  assign maxNow = s_q.ctrl[`ARS_CTRL_PCT] ? {1'b0, s_q.pmax} :
                  17'({1'b0, s_q.fmax} + {1'b0, slipComp});

  // Quotient back to a saturated signed percentage
  assign qc = (div.quo > {16'h0, `ARS_FULL2}) ? `ARS_FULL2 :
              div.quo[15:0];
  assign ys = s_q.neg ? 17'(s_q.y1) - $signed({1'b0, qc}) :
                        17'(s_q.y1) + $signed({1'b0, qc});

  // Magnitude and limit clamp, both directions alike
  assign mag  = s_q.yPct[15] ? 15'(-s_q.yPct) : s_q.yPct[14:0];
  assign rq   = (div.quo > {15'h0, s_q.maxEff}) ? s_q.maxEff :
                div.quo[16:0];
  assign rLim = (rq < {1'b0, s_q.minEff}) ? {1'b0, s_q.minEff} :
                rq;

  // Next state: register port, sample capture, sequencer
  always_comb begin
    s_d = s_q;
    s_d.valid  = 1'b0;
    s_d.dStart = 1'b0;
    s_d.rdOk   = regRdStb;
    if (regWrStb) begin
      case (regAddr)
        `ARS_ADR_CTRL: s_d.ctrl = regWrData[7:0];
        `ARS_ADR_FMIN: s_d.fmin = satU(regWrData, `ARS_F_LIM);
        `ARS_ADR_FMAX: s_d.fmax = satU(regWrData, `ARS_F_LIM);
        `ARS_ADR_PMIN: s_d.pmin = satU(regWrData, `ARS_P_LIM);
        `ARS_ADR_PMAX: s_d.pmax = satU(regWrData, `ARS_P_LIM);
        default: begin
          if (regAddr[7:6] == `ARS_PTS_TAG && regAddr[1:0] == 2'h0) begin
            s_d.pts[regAddr[5:4]][regAddr[3:2]] = regAddr[2] ?
              satY(regWrData) : satU(regWrData, `ARS_FULL);
          end
        end
      endcase
    end
    if (regRdStb) begin
      case (regAddr)
        `ARS_ADR_CTRL: s_d.rd = {24'h0, s_q.ctrl};
        `ARS_ADR_STAT: s_d.rd = {28'h0, s_q.st != ars_pkg::ST_IDLE,
                                 s_q.pend, s_q.rev, s_q.warn};
        `ARS_ADR_FMIN: s_d.rd = {16'h0, s_q.fmin};
        `ARS_ADR_FMAX: s_d.rd = {16'h0, s_q.fmax};
        `ARS_ADR_PMIN: s_d.rd = {16'h0, s_q.pmin};
        `ARS_ADR_PMAX: s_d.rd = {16'h0, s_q.pmax};
        `ARS_ADR_REF:  s_d.rd = {15'h0, s_q.refVal};
        default: begin
          if (regAddr[7:6] == `ARS_PTS_TAG && regAddr[1:0] == 2'h0) begin
            s_d.rd = {{16{regAddr[2] & s_q.pts[regAddr[5:4]]
                           [regAddr[3:2]][15]}},
                      s_q.pts[regAddr[5:4]][regAddr[3:2]]};
          end else begin
            s_d.rd = 32'h0;
          end
        end
      endcase
    end
    if (sampleValid) begin
      s_d.pend  = 1'b1;
      s_d.pendX = xIn;
      s_d.warn  = s_q.ctrl[`ARS_CTRL_MON] && isAnalog &&
                  (xIn < `ARS_LOW_LIM);
    end
    case (s_q.st)
      ars_pkg::ST_IDLE: begin
        if (s_q.pend) begin
          s_d.pend = sampleValid;
          if (isAnalog) begin
            // Snapshot settings for this sample
            s_d.fixed  = isFixed;
            s_d.y1     = py1;
            s_d.maxEff = maxNow;
            s_d.minEff = s_q.ctrl[`ARS_CTRL_PCT] ? s_q.pmin : s_q.fmin;
            s_d.neg    = num[33] ^ dx[16];
            s_d.dNum   = num[33] ? 32'(-num) : num[31:0];
            s_d.dDen   = dx[16] ? 32'(-dx) : {15'h0, dx};
            if (dx == 17'sh0) begin
              s_d.yPct = py1;
              s_d.st   = ars_pkg::ST_SCALE;
            end else begin
              s_d.dStart = 1'b1;
              s_d.st     = ars_pkg::ST_DIV1;
            end
          end
        end
      end
      ars_pkg::ST_DIV1: begin
        if (div.done) begin
          // Fixed curves never go below zero
          if (ys > $signed({1'b0, `ARS_FULL})) begin
            s_d.yPct = $signed(`ARS_FULL);
          end else if (s_q.fixed && ys < 17'sh0) begin
            s_d.yPct = 16'sh0000;
          end else if (ys < $signed({1'b1, `ARS_Y_NEG})) begin
            s_d.yPct = $signed(`ARS_Y_NEG);
          end else begin
            s_d.yPct = ys[15:0];
          end
          s_d.st = ars_pkg::ST_SCALE;
        end
      end
      ars_pkg::ST_SCALE: begin
        s_d.neg    = s_q.yPct[15];
        s_d.dNum   = 32'(mag * s_q.maxEff);
        s_d.dDen   = {16'h0, `ARS_FULL};
        s_d.dStart = 1'b1;
        s_d.st     = ars_pkg::ST_DIV2;
      end
      ars_pkg::ST_DIV2: begin
        if (div.done) begin
          s_d.refVal = (rLim > s_q.maxEff) ? s_q.maxEff : rLim;
          s_d.rev   = s_q.neg ^ dirRev;
          s_d.valid = 1'b1;
          s_d.st    = ars_pkg::ST_IDLE;
        end
      end
      default: s_d.st = ars_pkg::ST_IDLE;
    endcase
  end

  // State register with documented defaults
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q      <= '0;
      s_q.st   <= ars_pkg::ST_IDLE;
      s_q.ctrl <= `ARS_CTRL_RST;
      s_q.fmin <= `ARS_FMIN_RST;
      s_q.fmax <= `ARS_FMAX_RST;
      s_q.pmin <= `ARS_PMIN_RST;
      s_q.pmax <= `ARS_PMAX_RST;
      for (int i = 0; i < 4; i++) begin
        s_q.pts[i][0] <= `ARS_X1_RST;
        s_q.pts[i][1] <= `ARS_Y1_RST;
        s_q.pts[i][2] <= `ARS_X2_RST;
        s_q.pts[i][3] <= `ARS_Y2_RST;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops, except read data gated by rdOk
  assign regRdData  = s_q.rdOk ? s_q.rd : 32'h0;
  assign refOut     = s_q.refVal;
  assign refValid   = s_q.valid;
  assign reverseOut = s_q.rev;
  assign lowWarn    = s_q.warn;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // A sample taken by an idle analog sequencer
  sequence sTake;
    s_q.st == ars_pkg::ST_IDLE && s_q.pend && isAnalog;
  endsequence
  // The matching result leaves the setpoint path
  sequence sOut;
    ##[1:LAT] refValid;
  endsequence

  res_latency_a: assert property (sTake |-> sOut)
    else $error("no result after a taken sample");
  ref_bound_a: assert property (refValid |-> refOut <= s_q.maxEff &&
    (refOut >= {1'b0, s_q.minEff} || s_q.minEff > s_q.maxEff))
    else $error("reference outside limits");
  warn_set_a: assert property (sampleValid && s_q.ctrl[`ARS_CTRL_MON] &&
    isAnalog && xIn < `ARS_LOW_LIM |=> lowWarn)
    else $error("low signal warning missing");
  warn_off_a: assert property (sampleValid &&
    !s_q.ctrl[`ARS_CTRL_MON] |=> !lowWarn)
    else $error("warning while monitoring off");
  fix_dir_a: assert property (s_q.st == ars_pkg::ST_DIV2 && div.done &&
    s_q.fixed |=> reverseOut == $past(dirRev))
    else $error("fixed curve reversed rotation");
  x_range_a: assert property (regWrStb && regAddr == 8'h40 &&
    regWrData > 32'h2710 |=> s_q.pts[0][0] == `ARS_FULL)
    else $error("input point not saturated");
  y_range_a: assert property (regWrStb && regAddr == 8'h44 &&
    $signed(regWrData) < -32'sh2710 |=> s_q.pts[0][1] == `ARS_Y_NEG)
    else $error("output point not saturated");
  f_range_a: assert property (regWrStb && regAddr == `ARS_ADR_FMAX &&
    regWrData > 32'he9fc |=> s_q.fmax == `ARS_F_LIM)
    else $error("frequency limit not saturated");
  p_range_a: assert property (regWrStb && regAddr == `ARS_ADR_PMAX &&
    regWrData > 32'h7530 |=> s_q.pmax == `ARS_P_LIM)
    else $error("percentage limit not saturated");
  slip_max_a: assert property ((sTake and !s_q.ctrl[`ARS_CTRL_PCT])
    |=> s_q.maxEff == 17'({1'b0, $past(s_q.fmax)} +
                          {1'b0, $past(slipComp)}))
    else $error("slip not added to maximum");
endmodule : ars_scaler
`default_nettype wire

// >>> testbench/ars_src_model.sv
/*
  Analog source model: a converter that hands over one sample a request.
  Assumes: shared clock; the caller waits for each result before the next.
*/
`timescale 1ns/100ps
`default_nettype none
module ars_src_model #(
  parameter int ADC_W = 12
) (
  // Clock
  input  wire logic             clk,
  // Converted sample
  output logic      [ADC_W-1:0] sampleIn,
  output logic                  sampleValid
);
  // Quiet outputs before the first request
  initial begin
    sampleIn    = '0;
    sampleValid = 1'b0;
  end
  // One-cycle strobe, then the held code is released
  task automatic convert(input logic [ADC_W-1:0] code);
    @(posedge clk);
    sampleIn    <= code;
    sampleValid <= 1'b1;
    @(posedge clk);
    sampleValid <= 1'b0;
    sampleIn    <= ~code; // Stale code never lingers
  endtask : convert
endmodule : ars_src_model
`default_nettype wire

// >>> testbench/analog_reference_scaler_tb.sv
/*
  Self-checking bench of the analog reference scaler.
  Assumes: scaler and source model compiled before; 12-bit samples.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ars_params.svh"
module analog_reference_scaler_tb;
  logic        clk;
  logic        reset_n;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWrStb;
  logic        regRdStb;
  logic [31:0] regRdData;
  logic [11:0] sampleIn;
  logic        sampleValid;
  logic [1:0]  dataSet;
  logic        dirRev;
  logic [15:0] slipComp;
  logic [16:0] refOut;
  logic        refValid;
  logic        reverseOut;
  logic        lowWarn;
  int          errors;
  int          tests_run;

  ars_scaler #(.ADC_W(12)) uut (.clk(clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .sampleIn(sampleIn),
    .sampleValid(sampleValid), .dataSet(dataSet), .dirRev(dirRev),
    .slipComp(slipComp), .refOut(refOut), .refValid(refValid),
    .reverseOut(reverseOut), .lowWarn(lowWarn));
  ars_src_model #(.ADC_W(12)) src (.clk(clk), .sampleIn(sampleIn),
    .sampleValid(sampleValid));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Counts, verdict, end of run
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Compare and report
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge clk);
    regWrStb  <= 1'b0;
  endtask : wr

  // Register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    @(negedge clk);
    chk($sformatf("reg %h", a), exp, regRdData);
  endtask : rd

  // Send a sample, wait for its result, compare
  task automatic samp(input logic [11:0] code, input logic [16:0] eRef,
                      input logic eRev, input logic eWarn);
    int n;
    src.convert(code);
    @(negedge clk);
    chk("lowWarn", {31'h0, eWarn}, {31'h0, lowWarn});
    n = 0;
    while (refValid !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      errors++;
      $display("Error refValid: expected 1, seen 0");
      give_verdict();
    end
    chk("refOut", {15'h0, eRef}, {15'h0, refOut});
    chk("reverseOut", {31'h0, eRev}, {31'h0, reverseOut});
    @(negedge clk);
    chk("refValid pulse", 32'h0, {31'h0, refValid});
  endtask : samp

  // Reset state and register defaults
  task automatic t_reset();
    chk("refOut reset", 32'h0, {15'h0, refOut});
    chk("refValid reset", 32'h0, {31'h0, refValid});
    rd(8'h00, 32'h3);
    rd(8'h08, 32'h15e);
    rd(8'h0c, 32'h1388);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h2710);
    rd(8'h70, 32'hc8);
    rd(8'h74, 32'h0);
    rd(8'h78, 32'h2648);
    rd(8'h7c, 32'h2710);
    rd(8'h20, 32'h0);
  endtask : t_reset

  // Out-of-range writes saturate
  task automatic t_limits();
    wr(8'h0c, 32'h11170);
    rd(8'h0c, {16'h0, `ARS_F_LIM});
    wr(8'h14, 32'h9c40);
    rd(8'h14, {16'h0, `ARS_P_LIM});
    wr(8'h58, 32'h2ee0);
    rd(8'h58, 32'h2710);
    wr(8'h54, 32'hffffb1e0);
    rd(8'h54, 32'hffffd8f0);
    wr(8'h40, 32'h2ee0);
    rd(8'h40, 32'h2710);
    wr(8'h40, 32'hc8);
    wr(8'h44, 32'hffffb1e0);
    rd(8'h44, 32'hffffd8f0);
    wr(8'h44, 32'h0);
    wr(8'h0c, 32'h1388);
    wr(8'h14, 32'h2710);
  endtask : t_limits

  // Fixed curves in percentage mode
  task automatic t_fixed();
    wr(8'h00, 32'h09);
    samp(12'h052, 17'h0, 1'b0, 1'b0);
    samp(12'h800, 17'h1388, 1'b0, 1'b0);
    samp(12'hfff, 17'h2710, 1'b0, 1'b0);
    wr(8'h00, 32'h0a);
    samp(12'h800, 17'h1388, 1'b0, 1'b0);
    wr(8'h00, 32'h0d);
    samp(12'h800, 17'he64, 1'b0, 1'b0);
    samp(12'h052, 17'h0, 1'b0, 1'b0);
  endtask : t_fixed

  // Inverse bipolar user curve in set 2
  task automatic t_user();
    wr(8'h60, 32'hc8);
    wr(8'h64, 32'h2710);
    wr(8'h68, 32'h2648);
    wr(8'h6c, 32'hffffe0c0);
    wr(8'h10, 32'h7d0);
    wr(8'h00, 32'h0e);
    dataSet <= 2'h2;
    samp(12'hfff, 17'h1f40, 1'b1, 1'b0);
    samp(12'h000, 17'h2710, 1'b0, 1'b0);
    samp(12'h9b6, 17'h7d0, 1'b1, 1'b0);
    dirRev <= 1'b1;
    samp(12'hfff, 17'h1f40, 1'b0, 1'b0);
    dirRev <= 1'b0;
    wr(8'h00, 32'h0f);
    samp(12'h800, 17'h7d0, 1'b0, 1'b0);
    dataSet <= 2'h0;
    samp(12'h800, 17'h1388, 1'b0, 1'b0);
    wr(8'h10, 32'h0);
  endtask : t_user

  // Frequency limits with slip
  task automatic t_freq();
    slipComp <= 16'h0064;
    wr(8'h00, 32'h01);
    samp(12'h052, 17'h15e, 1'b0, 1'b0);
    samp(12'hfff, 17'h13ec, 1'b0, 1'b0);
    rd(8'h18, 32'h13ec);
    dirRev <= 1'b1;
    samp(12'hfff, 17'h13ec, 1'b1, 1'b0);
    dirRev <= 1'b0;
  endtask : t_freq

  // Low-signal monitoring with adjusted first point
  task automatic t_warn();
    wr(8'h40, 32'h3e8);
    wr(8'h00, 32'h16);
    samp(12'h052, 17'h15e, 1'b0, 1'b1);
    rd(8'h04, 32'h1);
    samp(12'h800, 17'h90d, 1'b0, 1'b0);
  endtask : t_warn

  // Digital mode gives no result
  task automatic t_refused();
    int hits;
    hits = 0;
    wr(8'h00, 32'h03);
    src.convert(12'h800);
    repeat (100) begin
      @(negedge clk);
      if (refValid === 1'b1) begin
        hits++;
      end
    end
    chk("refValid count", 32'h0, hits);
  endtask : t_refused

  // Main sequence
  initial begin
    reset_n   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 32'h0;
    regWrStb  = 1'b0;
    regRdStb  = 1'b0;
    dataSet   = 2'h0;
    dirRev    = 1'b0;
    slipComp  = 16'h0;
    errors    = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_limits();
    t_fixed();
    t_user();
    t_freq();
    t_warn();
    t_refused();
    give_verdict();
  end
endmodule : analog_reference_scaler_tb
`default_nettype wire
